/* dv/testbench.sv */
// testbench: self-checking bench of the bridge with a host model
// assumes 9600 baud at DIV_1200 = 96, so one uart bit is 12 cycles
`timescale 1ns/1ps
`default_nettype none
module testbench
    import urpb_pkg::*;
;
    logic clk = 0, rstn = 0, utx, ind, en, bit_o, rx_on, urx, sa, sb;
    logic rpre = 0, rsync = 0, rval = 0, rend = 0, wr = 0, rd = 0;
    logic [11:0] rword = 0;
    logic [7:0] addr = 0, b, r;
    logic [31:0] wdata = 0, rdata, d, seed = 32'h2f48e4fc;
    logic lo;
    int mismatches = 0, compares = 0;
    logic q[$];
    always #10 clk = ~clk;
    urpb_host_model #(.DIV(12)) host (.CLK_IN(clk), .TXD_OUT(urx),
        .SEL_A_OUT(sa), .SEL_B_OUT(sb));
    urpb_bridge #(.MS_CYC(50), .SEARCH_CYC(40), .DIV_1200(96)) dut (
        .CLK_IN(clk), .RSTN_IN(rstn), .UART_RX_IN(urx), .UART_TX_OUT(utx),
        .INDICATION_OUT(ind), .MODE_SELECT_A_IN(sa), .MODE_SELECT_B_IN(sb),
        .RADIO_TX_EN_OUT(en), .RADIO_TX_BIT_OUT(bit_o), .RADIO_RX_ON_OUT(rx_on),
        .RADIO_RX_PREAMBLE_IN(rpre), .RADIO_RX_SYNC_IN(rsync),
        .RADIO_RX_WORD_IN(rword), .RADIO_RX_WORD_VALID_IN(rval),
        .RADIO_RX_END_IN(rend), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
        .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata));
    ////////////////////////////////////////////////////////////////////
    // xorshift source, fixed seed so a failure repeats
    function automatic logic [7:0] rnd8();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    // coded word {parity, data}: each set data bit flips its column
    function automatic logic [11:0] code(input logic [7:0] v);
        logic [3:0] p;
        p = 4'h0;
        for (int i = 0; i < 8; i++)
            if (v[i])
                p ^= FEC_COLS[4*i +: 4];
        return {p, v};
    endfunction
    function automatic logic [7:0] crc8(input logic [7:0] v);
        for (int i = 0; i < 8; i++)
            v = v[7] ? {v[6:0], 1'b0} ^ CRC_POLY : {v[6:0], 1'b0};
        return v;
    endfunction
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // bounded wait; sampling 1 ns after the edge avoids update races
    task automatic wait_lvl(ref logic s, input logic v, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            #1;
            if (s === v)
                return;
        end
        mismatches++;
        $display("MISMATCH %0t timeout", $time);
        wrap_up();
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // one payload word then the crc word, end strictly after the last word
    task automatic radio_pkt(input logic [7:0] v, input logic [7:0] c);
        rsync <= 1'b1;
        @(posedge clk);
        rsync <= 1'b0;
        rword <= code(v);
        rval <= 1'b1;
        @(posedge clk);
        rword <= code(c);
        @(posedge clk);
        rval <= 1'b0;
        rend <= 1'b1;
        @(posedge clk);
        rend <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        wait_lvl(rstn, 1'b1, 2);
        chk({ind, utx, en, rx_on}, 4'b1101);
        reg_rd(REG_CFG, d);
        chk(d, 32'h3);
        reg_rd(REG_WAKE, d);
        chk(d, 32'(WAKE_MS_RST));
        b = rnd8();
        reg_wr(REG_WAKE, {24'h0, b});
        reg_rd(REG_WAKE, d);
        chk(d, {24'h0, b});
        reg_rd(8'h0c, d);
        chk(d, 32'h0);
        // every pin code, read back while idle
        for (int m = 3; m >= 0; m--) begin
            host.set_mode(2'(m));
            repeat (2) @(posedge clk);
            reg_rd(REG_STAT, d);
            chk(d[17:16], m);
        end
        // good packet is delivered, then a corrupted one is dropped
        b = rnd8();
        // normal-mode frames carry a short preamble, so listen without gaps
        chk(rx_on, 1'b1);
        radio_pkt(b, crc8(b));
        wait_lvl(ind, 1'b0, 3);
        wait_lvl(utx, 1'b0, 40);
        repeat (18) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            r[i] = utx;
            repeat (12) @(posedge clk);
        end
        chk(r, b);
        wait_lvl(ind, 1'b1, 40);
        radio_pkt(b, ~crc8(b));
        lo = 1'b0;
        repeat (200) begin
            @(posedge clk);
            #1 lo |= !ind | !utx;
        end
        chk(lo, 1'b0);
        // one host byte goes out framed after the idle gap
        b = rnd8();
        for (int i = 0; i < 40; i++)
            q.push_back(~i[0]);
        for (int i = 15; i >= 0; i--)
            q.push_back(SYNC_WORD[i]);
        d = 32'(code(b));
        for (int i = 11; i >= 0; i--)
            q.push_back(d[i]);
        host.send_byte(b);
        chk(ind, 1'b0);
        repeat (200) @(posedge clk);
        chk(en, 1'b0);
        wait_lvl(en, 1'b1, 300);
        chk(ind, 1'b1);
        host.set_mode(MODE_WAKE);
        // next packet goes in as soon as indication is high again
        host.send_byte(rnd8());
        repeat (504) @(posedge clk);
        foreach (q[i]) begin
            chk(bit_o, q[i]);
            repeat (1250) @(posedge clk);
        end
        wait_lvl(en, 1'b0, 16000);
        reg_rd(REG_STAT, d);
        chk(d[17:16], MODE_WAKE);
        // the queued packet leaves with no idle gap, buffer reported free
        wait_lvl(en, 1'b1, 2);
        chk(ind, 1'b1);
        wrap_up();
    end
endmodule
`default_nettype wire

/* dv/urpb_host_model.sv */
// urpb_host_model: host side of the bridge, serial sender and mode pins
// assumes 8N1 at DIV clock cycles per bit, driven just after rising edges
`timescale 1ns/1ps
`default_nettype none
module urpb_host_model #(
    parameter int DIV = 12
) (
    input  wire logic CLK_IN,
    output var logic  TXD_OUT,
    output var logic  SEL_A_OUT,
    output var logic  SEL_B_OUT
);
    // both select pins driven from time zero, never left floating
    initial begin
        TXD_OUT = 1'b1;
        SEL_A_OUT = 1'b0;
        SEL_B_OUT = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////
    // one 8N1 frame, lsb first, no parity bit; radio framing is the device's job
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            TXD_OUT <= f[i];
            repeat (DIV) @(posedge CLK_IN);
        end
    endtask
    // mode is {select a, select b}
    task automatic set_mode(input logic [1:0] m);
        SEL_A_OUT <= m[1];
        SEL_B_OUT <= m[0];
        @(posedge CLK_IN);
    endtask
endmodule
`default_nettype wire

/* verilog/urpb_bridge.sv */
// urpb_bridge: host uart to packet radio bridge with framing and checks
// assumes the radio front end delivers 12-bit coded words after sync
`timescale 1ns/1ps
`default_nettype none
// Function
// - device builds preamble, sync, coded payload, crc
// - preamble alternates 1010, normally 40 bits
// - two select pins choose four modes
// - first host byte lowers indication, samples b
// - idle 2-3 byte times then transmit
// - after sending, resample pins, enter mode
// - good received packet lowers indication, goes out
// - indication returns high after delivery
// - indication rises when transmission begins
// - packet arriving during transmission (indication high) skips idle wait
// - two 256-byte buffers, bursts near 256
// - seven baud rates, three parity settings
// - power saving wakes periodically, searches 16 bits
// - mode 1 sends lengthened preamble
// - wake mode preamble: interval plus 32 bits
// - power saving: uart off, periodic listening
// - sleep: uart off, outputs held
module urpb_bridge
    import urpb_pkg::*;
#(
    parameter int MS_CYC     = MS_CYC_DEF,
    parameter int SEARCH_CYC = SEARCH_CYC_DEF,
    parameter int DIV_1200   = DIV_1200_DEF
) (
    input  wire logic        CLK_IN,
    input  wire logic        RSTN_IN,
    input  wire logic        UART_RX_IN,
    output logic             UART_TX_OUT,
    output logic             INDICATION_OUT,
    input  wire logic        MODE_SELECT_A_IN,
    input  wire logic        MODE_SELECT_B_IN,
    output logic             RADIO_TX_EN_OUT,
    output logic             RADIO_TX_BIT_OUT,
    output logic             RADIO_RX_ON_OUT,
    input  wire logic        RADIO_RX_PREAMBLE_IN,
    input  wire logic        RADIO_RX_SYNC_IN,
    input  wire logic [11:0] RADIO_RX_WORD_IN,
    input  wire logic        RADIO_RX_WORD_VALID_IN,
    input  wire logic        RADIO_RX_END_IN,
    input  wire logic [7:0]  REG_ADDR_IN,
    input  wire logic [31:0] REG_WDATA_IN,
    input  wire logic        REG_WR_IN,
    input  wire logic        REG_RD_IN,
    output logic [31:0]      REG_RDATA_OUT
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [3:0] fec_par(input logic [7:0] d);
        logic [3:0] p;
        p = 4'h0;
        for (int j = 0; j < 8; j++) begin
            if (d[j]) p = p ^ FEC_COLS[j*4 +: 4];
        end
        return p;
    endfunction

    // single-bit errors are repaired, worse ones are left for the crc
    function automatic logic [7:0] fec_fix(input logic [11:0] cw);
        logic [3:0] syn;
        logic [7:0] d;
        syn = cw[11:8] ^ fec_par(cw[7:0]);
        d   = cw[7:0];
        for (int j = 0; j < 8; j++) begin
            if (syn == FEC_COLS[j*4 +: 4]) d[j] = ~d[j];
        end
        return d;
    endfunction

    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] x;
        x = c ^ d;
        for (int i = 0; i < 8; i++) begin
            x = x[7] ? ({x[6:0], 1'b0} ^ CRC_POLY) : {x[6:0], 1'b0};
        end
        return x;
    endfunction

    function automatic logic [15:0] baud_div(input logic [2:0] sel);
        unique case (sel)
            3'h0:    return 16'(DIV_1200);
            3'h1:    return 16'(DIV_1200 / 2);
            3'h2:    return 16'(DIV_1200 / 4);
            3'h3:    return 16'(DIV_1200 / 8);
            3'h4:    return 16'(DIV_1200 / 16);
            3'h5:    return 16'(DIV_1200 / 48);
            default: return 16'(DIV_1200 / 96);
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0]  mem_q [0:511];
    urpb_state_t st_q;
    logic [2:0]  baud_q;
    logic [1:0]  par_q;
    logic [12:0] wake_ms_q;
    logic [1:0]  mode_q;
    logic [31:0] rdata_q;
    logic        rx_busy_q, rx_done_q;
    logic [15:0] rx_div_q;
    logic [3:0]  rx_k_q;
    logic [10:0] rx_fr_q;
    logic        wb_q, fast_q, tx_long_q;
    logic [8:0]  cnt_q, tx_len_q, rcnt_q, di_q;
    logic [21:0] idle_q;
    logic [15:0] rf_cnt_q, ms_q, win_q;
    logic [12:0] msn_q;
    logic [19:0] bits_q;
    logic [15:0] sh_q;
    logic        pre_ph_q;
    logic [7:0]  crc_q;
    logic        utx_busy_q, utx_line_q;
    logic [15:0] utx_div_q;
    logic [3:0]  utx_k_q;
    logic [10:0] utx_sh_q;

    ////////////////////////////////////////////////////////////////////////////
    // decoding
    wire logic [15:0] bit_div  = baud_div(baud_q);
    wire logic        par_en   = par_q != PAR_NONE;
    wire logic [3:0]  fr_last  = par_en ? 4'ha : 4'h9;
    // uart receiver is off in saving and sleep, unless the host pulls select a low
    wire logic        host_en  = !mode_q[1] || !MODE_SELECT_A_IN;
    wire logic        stop_ok  = par_en ? rx_fr_q[10] : rx_fr_q[9];
    wire logic        par_ok   = !par_en || ((^rx_fr_q[9:1]) == (par_q == PAR_ODD));
    wire logic        byte_good = rx_done_q && !rx_fr_q[0] && stop_ok && par_ok;
    wire logic        byte_take = byte_good && cnt_q != 9'h100;
    wire logic [21:0] idle_lim = 22'(IDLE_BITS) * {6'h0, bit_div};
    wire logic        idle_done = idle_q >= idle_lim;
    wire logic        tx_busy  = st_q inside {ST_PRE, ST_SYNC, ST_DATA};
    wire logic        rf_tick  = rf_cnt_q == 16'h0;
    // a byte arriving this cycle blocks launch so it is never split off
    wire logic        launch   = st_q == ST_LISTEN && cnt_q != 9'h0 && !byte_good
                                 && (idle_done || fast_q);
    wire logic        rx_start = st_q == ST_LISTEN && !launch && RADIO_RX_SYNC_IN
                                 && RADIO_RX_ON_OUT;
    wire logic [7:0]  rd_byte  = mem_q[{~wb_q, di_q[7:0]}];
    wire logic [7:0]  tx_byte  = (di_q == tx_len_q) ? crc_q : rd_byte;
    wire logic [7:0]  rx_fixed = fec_fix(RADIO_RX_WORD_IN);
    wire logic [8:0]  dlen     = rcnt_q - 9'h1;
    wire logic        utx_load = st_q == ST_DLV && !utx_busy_q && di_q != dlen;
    wire logic [19:0] pre_len  = tx_long_q
        ? 20'(wake_ms_q * RF_BITS_PER_MS + PRE_EXTRA_BITS) : 20'(PRE_BITS);
    wire logic [1:0]  pins     = {MODE_SELECT_A_IN, MODE_SELECT_B_IN};

    // outputs derived from flops
    assign INDICATION_OUT   = !(cnt_q != 9'h0 || st_q == ST_DLV);
    assign RADIO_TX_EN_OUT  = tx_busy;
    assign RADIO_TX_BIT_OUT = tx_busy && (st_q == ST_PRE ? pre_ph_q : sh_q[15]);
    assign RADIO_RX_ON_OUT  = st_q == ST_RX || (st_q == ST_LISTEN
        && (!mode_q[1] || (mode_q == MODE_SAVE && win_q != 16'h0)));
    assign UART_TX_OUT      = utx_line_q;
    assign REG_RDATA_OUT    = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // register port: read data appear only in the cycle after the strobe
    wire logic [31:0] rd_mux =
        (REG_ADDR_IN == REG_CFG)  ? {26'h0, par_q, 1'b0, baud_q} :
        (REG_ADDR_IN == REG_WAKE) ? {19'h0, wake_ms_q} :
        (REG_ADDR_IN == REG_STAT) ? {13'h0, INDICATION_OUT, mode_q, st_q, 1'b0, cnt_q} :
        32'h0;

    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            baud_q    <= BAUD_RST;
            par_q     <= PAR_NONE;
            wake_ms_q <= WAKE_MS_RST;
            rdata_q   <= 32'h0;
        end else begin
            rdata_q <= REG_RD_IN ? rd_mux : 32'h0;
            if (REG_WR_IN && REG_ADDR_IN == REG_CFG) begin
                baud_q <= REG_WDATA_IN[2:0];
                par_q  <= REG_WDATA_IN[5:4];
            end
            if (REG_WR_IN && REG_ADDR_IN == REG_WAKE) wake_ms_q <= REG_WDATA_IN[12:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // host uart receiver, mid-bit sampling
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            rx_busy_q <= 1'b0;
            rx_done_q <= 1'b0;
            rx_div_q  <= 16'h0;
            rx_k_q    <= 4'h0;
            rx_fr_q   <= 11'h7ff;
        end else begin
            rx_done_q <= 1'b0;
            if (!rx_busy_q) begin
                if (host_en && !UART_RX_IN) begin
                    rx_busy_q <= 1'b1;
                    rx_div_q  <= bit_div >> 1;
                    rx_k_q    <= 4'h0;
                end
            end else if (rx_div_q != 16'h0) begin
                rx_div_q <= rx_div_q - 16'h1;
            end else begin
                rx_div_q        <= bit_div - 16'h1;
                rx_fr_q[rx_k_q] <= UART_RX_IN;
                rx_k_q          <= rx_k_q + 4'h1;
                if (rx_k_q == fr_last) begin
                    rx_busy_q <= 1'b0;
                    rx_done_q <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // host buffer fill, idle gap and launch; banks swap at launch
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            wb_q      <= 1'b0;
            cnt_q     <= 9'h0;
            tx_len_q  <= 9'h0;
            idle_q    <= 22'h0;
            fast_q    <= 1'b0;
            tx_long_q <= 1'b0;
        end else begin
            if (byte_take) begin
                cnt_q  <= cnt_q + 9'h1;
                idle_q <= 22'h0;
                if (cnt_q == 9'h0) begin
                    tx_long_q <= MODE_SELECT_B_IN;
                    fast_q    <= INDICATION_OUT && tx_busy;
                end
            end else if (launch) begin
                wb_q     <= ~wb_q;
                cnt_q    <= 9'h0;
                tx_len_q <= cnt_q;
                fast_q   <= 1'b0;
            end else if (!idle_done) begin
                idle_q <= idle_q + 22'h1;
            end
        end
    end

    // both banks share one array; host writes wb, radio side uses the other
    always_ff @(posedge CLK_IN) begin
        if (byte_take) mem_q[{wb_q, cnt_q[7:0]}] <= rx_fr_q[8:1];
        if (st_q == ST_RX && RADIO_RX_WORD_VALID_IN && rcnt_q != 9'h100) begin
            mem_q[{~wb_q, rcnt_q[7:0]}] <= rx_fixed;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // radio sequencer: frame out, frame in, delivery to host
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            st_q     <= ST_LISTEN;
            mode_q   <= MODE_NORMAL;
            rf_cnt_q <= 16'h0;
            bits_q   <= 20'h0;
            sh_q     <= 16'h0;
            pre_ph_q <= 1'b1;
            di_q     <= 9'h0;
            rcnt_q   <= 9'h0;
            crc_q    <= 8'h0;
        end else begin
            rf_cnt_q <= (launch || rf_tick) ? 16'(RF_BIT_CYC - 1) : rf_cnt_q - 16'h1;
            unique case (st_q)
                ST_LISTEN: begin
                    if (launch) begin
                        st_q     <= ST_PRE;
                        bits_q   <= pre_len;
                        pre_ph_q <= 1'b1;
                        crc_q    <= 8'h0;
                        di_q     <= 9'h0;
                    end else if (rx_start) begin
                        st_q   <= ST_RX;
                        rcnt_q <= 9'h0;
                        crc_q  <= 8'h0;
                    end else if (cnt_q == 9'h0) begin
                        mode_q <= pins;   // idle follows the select pins
                    end
                end
                ST_PRE: if (rf_tick) begin
                    pre_ph_q <= ~pre_ph_q;
                    bits_q   <= bits_q - 20'h1;
                    if (bits_q == 20'h1) begin
                        st_q   <= ST_SYNC;
                        sh_q   <= SYNC_WORD;
                        bits_q <= 20'(SYNC_BITS);
                    end
                end
                ST_SYNC, ST_DATA: if (rf_tick) begin
                    sh_q   <= {sh_q[14:0], 1'b0};
                    bits_q <= bits_q - 20'h1;
                    if (bits_q == 20'h1) begin
                        if (di_q > tx_len_q) begin
                            st_q   <= ST_LISTEN;
                            mode_q <= pins;
                        end else begin
                            st_q   <= ST_DATA;
                            sh_q   <= {fec_par(tx_byte), tx_byte, 4'h0};
                            bits_q <= 20'(CW_BITS);
                            di_q   <= di_q + 9'h1;
                            if (di_q != tx_len_q) crc_q <= crc8(crc_q, rd_byte);
                        end
                    end
                end
                ST_RX: begin
                    if (RADIO_RX_WORD_VALID_IN) begin
                        crc_q <= crc8(crc_q, rx_fixed);
                        if (rcnt_q != 9'h100) rcnt_q <= rcnt_q + 9'h1;
                    end
                    if (RADIO_RX_END_IN) begin
                        di_q <= 9'h0;
                        // bad frames leave without touching indication or uart
                        st_q <= (crc_q == 8'h0 && rcnt_q > 9'h1) ? ST_DLV : ST_LISTEN;
                    end
                end
                ST_DLV: begin
                    if (utx_load) di_q <= di_q + 9'h1;
                    else if (!utx_busy_q && di_q == dlen) st_q <= ST_LISTEN;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // periodic wake-up search in power saving; a seen preamble holds it open
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            ms_q  <= 16'h0;
            msn_q <= 13'h0;
            win_q <= 16'h0;
        end else if (mode_q != MODE_SAVE || st_q != ST_LISTEN) begin
            ms_q  <= 16'h0;
            msn_q <= 13'h0;
            win_q <= 16'h0;
        end else if (win_q != 16'h0) begin
            if (!RADIO_RX_PREAMBLE_IN) win_q <= win_q - 16'h1;
        end else if (ms_q == 16'(MS_CYC - 1)) begin
            ms_q <= 16'h0;
            if (msn_q + 13'h1 >= wake_ms_q) begin
                msn_q <= 13'h0;
                win_q <= 16'(SEARCH_CYC);
            end else begin
                msn_q <= msn_q + 13'h1;
            end
        end else begin
            ms_q <= ms_q + 16'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // host uart transmitter; line idles high and is held in sleep
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            utx_busy_q <= 1'b0;
            utx_line_q <= 1'b1;
            utx_div_q  <= 16'h0;
            utx_k_q    <= 4'h0;
            utx_sh_q   <= 11'h7ff;
        end else if (!utx_busy_q) begin
            if (utx_load) begin
                utx_busy_q <= 1'b1;
                utx_line_q <= 1'b0;
                utx_div_q  <= bit_div - 16'h1;
                utx_k_q    <= 4'h0;
                utx_sh_q   <= {1'b1, par_en ? ((par_q == PAR_ODD) ^ (^rd_byte)) : 1'b1,
                               rd_byte, 1'b0};
            end
        end else if (utx_div_q != 16'h0) begin
            utx_div_q <= utx_div_q - 16'h1;
        end else begin
            utx_div_q  <= bit_div - 16'h1;
            utx_sh_q   <= {1'b1, utx_sh_q[10:1]};
            utx_line_q <= utx_sh_q[1];
            utx_k_q    <= utx_k_q + 4'h1;
            if (utx_k_q == fr_last) utx_busy_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RSTN_IN);

    property p_idle_high;
        st_q == ST_LISTEN && cnt_q == 9'h0 |-> INDICATION_OUT;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("indication low when idle");
    property p_first_low;
        byte_take && cnt_q == 9'h0 |=> !INDICATION_OUT && tx_long_q == $past(MODE_SELECT_B_IN);
    endproperty
    a_first_low: assert property (p_first_low) else $error("first byte not seen");
    property p_launch_high;
        launch |=> INDICATION_OUT && RADIO_TX_EN_OUT && RADIO_TX_BIT_OUT;
    endproperty
    a_launch_high: assert property (p_launch_high) else $error("launch lost");
    property p_gap;
        launch |-> fast_q || idle_q >= idle_lim;
    endproperty
    a_gap: assert property (p_gap) else $error("launched before idle gap");
    property p_fast;
        st_q == ST_LISTEN && fast_q && cnt_q != 9'h0 && !byte_good |-> launch;
    endproperty
    a_fast: assert property (p_fast) else $error("queued packet waited");
    property p_pre_alt;
        st_q == ST_PRE && rf_tick && bits_q > 20'h1 |=> RADIO_TX_BIT_OUT != $past(RADIO_TX_BIT_OUT);
    endproperty
    a_pre_alt: assert property (p_pre_alt) else $error("preamble not alternating");
    property p_mode_after_tx;
        st_q == ST_DATA && rf_tick && bits_q == 20'h1 && di_q > tx_len_q
            |=> st_q == ST_LISTEN && mode_q == $past(pins);
    endproperty
    a_mode_after_tx: assert property (p_mode_after_tx) else $error("mode not taken");
    property p_bad_drop;
        st_q == ST_RX && RADIO_RX_END_IN && crc_q != 8'h0 |=> st_q == ST_LISTEN ##1 UART_TX_OUT;
    endproperty
    a_bad_drop: assert property (p_bad_drop) else $error("bad frame delivered");
    property p_good_dlv;
        st_q == ST_RX && RADIO_RX_END_IN && crc_q == 8'h0 && rcnt_q > 9'h1
            |=> !INDICATION_OUT ##1 !UART_TX_OUT;
    endproperty
    a_good_dlv: assert property (p_good_dlv) else $error("good frame not delivered");
    property p_sleep;
        mode_q == MODE_SLEEP && st_q == ST_LISTEN |-> !RADIO_RX_ON_OUT;
    endproperty
    a_sleep: assert property (p_sleep) else $error("receiver on in sleep");

    c_long: cover property (launch && tx_long_q);
    c_fast: cover property (launch && fast_q);
    c_dlv:  cover property (st_q == ST_DLV ##1 st_q == ST_DLV);
    c_win:  cover property (win_q != 16'h0 && RADIO_RX_PREAMBLE_IN);

endmodule
`default_nettype wire

/* verilog/urpb_pkg.sv */
// urpb_pkg: constants and types of the uart to radio packet bridge
// assumes one 50 MHz clock domain and a radio front end that delivers 12-bit coded words
package urpb_pkg;
    // timing base
    localparam int CLK_HZ         = 50_000_000;
    localparam int RF_BPS         = 40000;
    localparam int RF_BIT_CYC     = CLK_HZ / RF_BPS;
    localparam int RF_BITS_PER_MS = RF_BPS / 1000;
    localparam int MS_CYC_DEF     = CLK_HZ / 1000;
    localparam int DIV_1200_DEF   = CLK_HZ / 1200;
    // frame layout, in bits
    localparam int PRE_BITS       = 40;
    localparam int PRE_EXTRA_BITS = 32;
    localparam int SEARCH_BITS    = 16;
    localparam int SEARCH_CYC_DEF = SEARCH_BITS * RF_BIT_CYC;
    localparam int SYNC_BITS      = 16;
    localparam int CW_BITS        = 12;
    localparam int IDLE_BITS      = 30;
    localparam logic [15:0] SYNC_WORD = 16'h2dd4;
    localparam logic [7:0]  CRC_POLY  = 8'h07;
    // error coding: parity column of each data bit, bit 0 lowest
    localparam logic [31:0] FEC_COLS  = 32'hcba97653;
    // register map and reset values
    localparam logic [7:0]  REG_CFG     = 8'h00;
    localparam logic [7:0]  REG_WAKE    = 8'h04;
    localparam logic [7:0]  REG_STAT    = 8'h08;
    localparam logic [2:0]  BAUD_RST    = 3'h3;
    localparam logic [12:0] WAKE_MS_RST = 13'h03e8;
    localparam logic [1:0]  PAR_NONE    = 2'h0;
    localparam logic [1:0]  PAR_EVEN    = 2'h1;
    localparam logic [1:0]  PAR_ODD     = 2'h2;
    // working modes, coded as {select a, select b}
    localparam logic [1:0]  MODE_NORMAL = 2'h0;
    localparam logic [1:0]  MODE_WAKE   = 2'h1;
    localparam logic [1:0]  MODE_SAVE   = 2'h2;
    localparam logic [1:0]  MODE_SLEEP  = 2'h3;
    typedef enum logic [5:0] {
        ST_LISTEN = 6'h01,
        ST_PRE    = 6'h02,
        ST_SYNC   = 6'h04,
        ST_DATA   = 6'h08,
        ST_RX     = 6'h10,
        ST_DLV    = 6'h20
    } urpb_state_t;
endpackage
